// [core/acop_pkg.sv]
package acop_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 25;
	localparam int CONV_TIME_NS = 1000;  // Conversion length, plain default
	localparam int ACQ_TIME_NS  = 250;   // Least acquisition time, plain default
	// Least times round up to whole cycles
	localparam int CONV_CYC     = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ACQ_CYC      = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W        = 8;
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
	localparam logic [CNT_W-1:0] ACQ_LAST  = CNT_W'(ACQ_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

	// Internal bit clock: half period in system cycles
	localparam int SCLK_HALF_CYC = 1;
	localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// Word and pin layout
	// ----------------------------------------------------------------
	localparam int RES_W      = 16;
	localparam int BUS_W      = 16;
	localparam int PIN_SERIAL_RESULT_OUT  = 8;
	localparam int PIN_SCLK   = 9;
	localparam int PIN_SYNC   = 10;
	localparam int PIN_ERR    = 11;
	localparam int PIN_HIZ_LO = 12;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] LAST_BIT  = 5'h0f;
	localparam logic [3:0] M_LAST    = 4'hf;
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic resetIn;            // High aborts conversion and master shifting
		logic powerDownIn;        // High inhibits new conversions
		logic lowPowerSelect;     // Reduced power mode select
		logic fastModeSelect;     // Fastest mode select
		logic readModeOrChainIn;  // Read mode (internal) or chain data (external)
		logic frameSyncInvert;    // Frame sync polarity
		logic bitClockInvert;     // Data update edge select
		logic clockSourceSelect;  // High: external bit clock
		logic portFormatSelect;   // High: serial port
		logic conversionStartN;   // Falling edge starts a conversion
	} acop_pins_type;

	typedef struct packed {
		logic [BUS_W-1:0] out;
		logic [BUS_W-1:0] oe;
	} acop_bus_type;

	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_CONV = 3'b010,
		C_ACQ  = 3'b100
	} acop_conv_state_type;

	typedef enum logic [1:0] {
		M_IDLE  = 2'b01,
		M_SHIFT = 2'b10
	} acop_mstate_type;

endpackage : acop_pkg

// [core/acop_port.sv]
// Contract
// [RULE_01] Parallel mode: shared pins carry bits 9-11; the code shares pins 8-11 and drives them with bits 8-11
// [RULE_02] Bit clock pin: output internal, input external
// [RULE_03] Clock-invert input picks the data update edge
// [RULE_04] Serial mode provides a frame-sync output; the code drives it only with the internal bit clock
// [RULE_05] Sync-invert low: sync high while data valid
// [RULE_06] Sync-invert high: sync low while data valid
// [RULE_07] Error pin only in external serial mode
// [RULE_08] Overrun read: drop result, pulse error flag
// [RULE_09] Bits 12-15 driven parallel, released serial
// [RULE_10] Busy high from start until result latched
// [RULE_11] Host may use busy fall as ready
// [RULE_12] Drivers enabled only with select and read low
// [RULE_13] External clock ignored unless select low
// [RULE_14] Reset input high aborts any conversion
// [RULE_15] Power-down finishes current, blocks new starts
// [RULE_16] Start falling edge holds sample, begins conversion
// [RULE_17] Low-power mode: start low at acquisition end
// [RULE_18] External clock: update rising, capture falling
// [RULE_19] Serial result goes out MSB first
// [RULE_20] Read mode: previous data during, else after
// [RULE_21] Chain input forwarded after sixteen bit clocks
// [RULE_22] Start edges while busy are ignored
// [RULE_23] Error pulse one cycle, at overrun completion
`timescale 1ns/100ps
module acop_port
	import acop_pkg::*;
(
	input  wire logic             clk,         // System clock, 25 MHz
	input  wire logic             arst_n,      // Async reset, active low
	input  wire acop_pins_type    pinsIn,      // Control and strap pins
	input  wire logic             csN,         // Chip select, active low
	input  wire logic             rdN,         // Read strobe, active low
	input  wire logic             bitClockIn,  // Bit clock pin, input side
	input  wire logic [RES_W-1:0] convResult,  // Code from the converter core
	output logic                  busy,        // Conversion in progress
	output logic                  holdSample,  // Sample-and-hold in hold
	output logic                  reducedPower,// Power-down in effect
	output acop_bus_type          dataBus      // Shared data pins
);

	// ----------------------------------------------------------------
	// Pin synchronisation into the system domain
	// ----------------------------------------------------------------
	acop_pins_type pinsS;
	logic [1:0]    tglS;
	logic          startTglQ;
	logic          doneTglQ;

	acop_sync #(.W($bits(acop_pins_type))) uPinSync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (pinsIn),
		.q      (pinsS)
	);

	// Read start and read done events arrive as toggles from the link
	acop_sync #(.W(2)) uTglSync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({doneTglQ, startTglQ}),
		.q      (tglS)
	);

	// ----------------------------------------------------------------
	// Link domain: external bit clock slave shifter
	// ----------------------------------------------------------------
	logic             linkClk;
	logic             linkRstN;
	logic [4:0]       lnkCntQ;
	logic [4:0]       lnkCntD;
	logic [RES_W-1:0] lnkShiftQ;
	logic [RES_W-1:0] lnkShiftD;
	logic             lnkBitQ;
	logic             lnkBitD;
	logic             startTglD;
	logic             doneTglD;
	logic [RES_W-1:0] holdQ;
	logic [RES_W-1:0] holdD;

	// Inverting the pin moves the update edge to the falling edge
	assign linkClk  = bitClockIn ^ pinsIn.bitClockInvert;  // see [RULE_03]
	// Deselect clears the frame, so stray clocks never advance it
	assign linkRstN = arst_n & ~csN;                       // see [RULE_13]

	// Next frame state: MSB at the first update edge, then chain data
	always_comb begin
		lnkCntD   = lnkCntQ;
		lnkShiftD = lnkShiftQ;
		lnkBitD   = lnkBitQ;
		startTglD = startTglQ;
		doneTglD  = doneTglQ;
		if (lnkCntQ == 5'h00) begin
			// Hold register only changes at conversion end, so it is quiet here
			lnkBitD   = holdQ[RES_W-1];                       // see [RULE_19]
			lnkShiftD = {holdQ[RES_W-2:0], 1'b0};
			lnkCntD   = lnkCntQ + 5'h01;
			if (!csN) begin
				startTglD = ~startTglQ;
			end
		end else if (lnkCntQ < WORD_BITS) begin
			lnkBitD   = lnkShiftQ[RES_W-1];                   // see [RULE_18]
			lnkShiftD = {lnkShiftQ[RES_W-2:0], 1'b0};
			lnkCntD   = lnkCntQ + 5'h01;
			if (lnkCntQ == LAST_BIT && !csN) begin
				doneTglD = ~doneTglQ;
			end
		end else begin
			lnkBitD = pinsIn.readModeOrChainIn;               // see [RULE_21]
		end
	end

	// Frame registers, cleared whenever the host deselects
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			lnkCntQ   <= 5'h00;
			lnkShiftQ <= 16'h0000;
			lnkBitQ   <= 1'b0;
		end else begin
			lnkCntQ   <= lnkCntD;
			lnkShiftQ <= lnkShiftD;
			lnkBitQ   <= lnkBitD;
		end
	end

	// Event toggles survive deselect so the other side sees every one
	always_ff @(posedge linkClk or negedge arst_n) begin
		if (!arst_n) begin
			startTglQ <= 1'b0;
			doneTglQ  <= 1'b0;
		end else begin
			startTglQ <= startTglD;
			doneTglQ  <= doneTglD;
		end
	end

	// ----------------------------------------------------------------
	// Conversion control
	// ----------------------------------------------------------------
	acop_conv_state_type cStateQ;
	acop_conv_state_type cStateD;
	logic [CNT_W-1:0]    cCntQ;
	logic [CNT_W-1:0]    cCntD;
	logic                cnvPrevQ;
	logic                pendQ;
	logic                pendD;
	logic                errQ;
	logic                errD;
	logic [1:0]          tglSeenQ;
	logic                startEdge;
	logic                readStart;
	logic                readDone;
	logic                lowPowerMode;
	logic                slaveSerial;
	logic                convStart;
	logic                convDone;

	assign startEdge    = cnvPrevQ & ~pinsS.conversionStartN;
	assign readStart    = tglS[0] ^ tglSeenQ[0];
	assign readDone     = tglS[1] ^ tglSeenQ[1];
	assign lowPowerMode = pinsS.lowPowerSelect & ~pinsS.fastModeSelect;
	assign slaveSerial  = pinsS.portFormatSelect & pinsS.clockSourceSelect;

	// Next conversion state, hold register, read tracking and error pulse
	always_comb begin
		cStateD   = cStateQ;
		cCntD     = cCntQ;
		holdD     = holdQ;
		errD      = 1'b0;
		convStart = 1'b0;
		convDone  = 1'b0;
		// A read start in the clearing cycle keeps the read pending
		pendD     = (pendQ & ~readDone) | readStart;
		unique case (cStateQ)
			C_IDLE: begin
				// Edges only count here or after the conversion is over
				if (startEdge && !pinsS.powerDownIn) begin  // see [RULE_15]
					cStateD   = C_CONV;                          // see [RULE_16]
					cCntD     = '0;
					convStart = 1'b1;
				end
			end
			C_CONV: begin
				// No start edge is looked at while converting, see [RULE_22]
				if (cCntQ == CONV_LAST) begin
					convDone = 1'b1;
					cStateD  = C_ACQ;
					cCntD    = '0;
					if (pendQ && slaveSerial) begin
						errD = 1'b1;                             // see [RULE_08] see [RULE_23]
					end else begin
						holdD = convResult;                      // see [RULE_10]
					end
				end else begin
					cCntD = cCntQ + CNT_ONE;
				end
			end
			C_ACQ: begin
				if (startEdge && !pinsS.powerDownIn) begin
					cStateD   = C_CONV;
					cCntD     = '0;
					convStart = 1'b1;
				end else if (cCntQ == ACQ_LAST) begin
					cCntD = '0;
					// Start held low through acquisition starts at once
					if (lowPowerMode && !pinsS.conversionStartN && !pinsS.powerDownIn) begin
						cStateD   = C_CONV;                      // see [RULE_17]
						convStart = 1'b1;
					end else begin
						cStateD = C_IDLE;
					end
				end else begin
					cCntD = cCntQ + CNT_ONE;
				end
			end
		endcase
		if (pinsS.resetIn) begin
			cStateD   = C_IDLE;                                  // see [RULE_14]
			cCntD     = '0;
			convStart = 1'b0;
			convDone  = 1'b0;
			errD      = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cStateQ  <= C_IDLE;
			cCntQ    <= '0;
			cnvPrevQ <= 1'b0;
			holdQ    <= 16'h0000;
			pendQ    <= 1'b0;
			errQ     <= 1'b0;
			tglSeenQ <= 2'h0;
		end else begin
			cStateQ  <= cStateD;
			cCntQ    <= cCntD;
			cnvPrevQ <= pinsS.conversionStartN;
			holdQ    <= holdD;
			pendQ    <= pendD;
			errQ     <= errD;
			tglSeenQ <= tglS;
		end
	end

	// Busy falls in the same edge that loads the hold register
	assign busy         = (cStateQ == C_CONV);                  // see [RULE_10] see [RULE_11]
	assign holdSample   = busy;
	assign reducedPower = pinsS.powerDownIn & ~busy;            // see [RULE_15]

	// ----------------------------------------------------------------
	// Internal bit clock master shifter
	// ----------------------------------------------------------------
	acop_mstate_type  mStateQ;
	acop_mstate_type  mStateD;
	logic [3:0]       mCntQ;
	logic [3:0]       mCntD;
	logic [3:0]       halfQ;
	logic [3:0]       halfD;
	logic [RES_W-1:0] mShiftQ;
	logic [RES_W-1:0] mShiftD;
	logic             mBitQ;
	logic             mBitD;
	logic             sclkQ;
	logic             sclkD;
	logic             sclkIdle;
	logic             mTrigger;

	// Idle level makes the first edge a capture edge for the MSB
	assign sclkIdle = ~pinsS.bitClockInvert;                    // see [RULE_03]
	assign mTrigger = pinsS.portFormatSelect & ~pinsS.clockSourceSelect
		& (pinsS.readModeOrChainIn ? convStart : convDone);     // see [RULE_20]

	// Next master state; holdD gives the old word at start, new at done
	always_comb begin
		mStateD = mStateQ;
		mCntD   = mCntQ;
		halfD   = halfQ;
		mShiftD = mShiftQ;
		mBitD   = mBitQ;
		sclkD   = sclkQ;
		unique case (mStateQ)
			M_IDLE: begin
				sclkD = sclkIdle;
				halfD = 4'h0;
				if (mTrigger) begin
					mStateD = M_SHIFT;
					mCntD   = 4'h0;
					mBitD   = holdD[RES_W-1];                    // see [RULE_19]
					mShiftD = {holdD[RES_W-2:0], 1'b0};
				end
			end
			M_SHIFT: begin
				if (halfQ == SCLK_HALF_LAST) begin
					halfD = 4'h0;
					sclkD = ~sclkQ;
					// Returning to idle level is the update edge
					if (sclkQ != sclkIdle) begin
						if (mCntQ == M_LAST) begin
							mStateD = M_IDLE;
						end else begin
							mBitD   = mShiftQ[RES_W-1];
							mShiftD = {mShiftQ[RES_W-2:0], 1'b0};
							mCntD   = mCntQ + 4'h1;
						end
					end
				end else begin
					halfD = halfQ + 4'h1;
				end
			end
		endcase
		if (pinsS.resetIn) begin
			mStateD = M_IDLE;
			sclkD   = sclkIdle;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mStateQ <= M_IDLE;
			mCntQ   <= 4'h0;
			halfQ   <= 4'h0;
			mShiftQ <= 16'h0000;
			mBitQ   <= 1'b0;
			sclkQ   <= 1'b1;
		end else begin
			mStateQ <= mStateD;
			mCntQ   <= mCntD;
			halfQ   <= halfD;
			mShiftQ <= mShiftD;
			mBitQ   <= mBitD;
			sclkQ   <= sclkD;
		end
	end

	// ----------------------------------------------------------------
	// Shared data pins
	// ----------------------------------------------------------------
	logic busEnable;
	logic syncLevel;

	// Straight from the pins: drivers must release without a clock
	assign busEnable = ~csN & ~rdN;                             // see [RULE_12]
	// Active level of sync marks valid serial data
	assign syncLevel = (mStateQ == M_SHIFT) ^ pinsS.frameSyncInvert;  // see [RULE_05] see [RULE_06]

	// Pin function and driver enables per port format
	always_comb begin
		dataBus.out = '0;
		dataBus.oe  = '0;
		if (!pinsS.portFormatSelect) begin
			dataBus.out = holdQ;                                 // see [RULE_01]
			dataBus.oe  = {BUS_W{busEnable}};                    // see [RULE_09]
		end else begin
			dataBus.out[PIN_SERIAL_RESULT_OUT] = pinsS.clockSourceSelect ? lnkBitQ : mBitQ;
			dataBus.out[PIN_SCLK]  = sclkQ;
			dataBus.out[PIN_SYNC]  = syncLevel;                  // see [RULE_04]
			dataBus.out[PIN_ERR]   = errQ;
			dataBus.oe[PIN_SERIAL_RESULT_OUT]  = busEnable;
			dataBus.oe[PIN_SCLK]   = busEnable & ~pinsS.clockSourceSelect;  // see [RULE_02]
			dataBus.oe[PIN_SYNC]   = busEnable & ~pinsS.clockSourceSelect;
			dataBus.oe[PIN_ERR]    = busEnable & pinsS.clockSourceSelect;   // see [RULE_07]
		end
	end

endmodule : acop_port

// [core/acop_sync.sv]
`timescale 1ns/100ps
module acop_sync
	import acop_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,     // Destination clock
	input  wire logic         arst_n,  // Async reset, active low
	input  wire logic [W-1:0] d,       // Foreign levels
	output logic      [W-1:0] q        // Settled levels
);

	// ----------------------------------------------------------------
	// Per-bit three-stage synchroniser with agreement filter
	// ----------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : gBit
		logic s1Q;
		logic s2Q;
		logic s3Q;
		logic qQ;
		logic qD;

		// First stage feeds only the second; filter looks at stages two and three
		always_comb begin
			qD = (s2Q == s3Q) ? s3Q : qQ;
		end

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				s1Q <= 1'b0;
				s2Q <= 1'b0;
				s3Q <= 1'b0;
				qQ  <= 1'b0;
			end else begin
				s1Q <= d[i];
				s2Q <= s1Q;
				s3Q <= s2Q;
				qQ  <= qD;
			end
		end

		assign q[i] = qQ;
	end

endmodule : acop_sync

// [testbench/acop_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host model: select, read strobe, 12 ns bit clock
// ----------------------------------------------------------------
module acop_host_model
	import acop_pkg::*;
(
	input  wire logic       go,         // Start one frame
	input  wire logic [4:0] nBits,      // Bit clocks in frame
	input  wire logic       inv,        // Update on falling edge
	input  wire logic       keep,       // Leave select low after
	input  wire logic       selIn,      // Hold select and read low
	input  wire logic       serialIn,   // Serial data wire
	output logic            csN,        // Chip select
	output logic            rdN,        // Read strobe
	output logic            bitClockIn, // Bit clock, still between frames
	output logic [17:0]     word,       // Bits taken, MSB first
	output logic            done        // Frame finished
);
	logic frame;

	assign csN = !(selIn || frame);
	assign rdN = csN;

	// Odd 3 ns offset keeps every link edge off the system clock edge
	initial begin
		frame = 1'b0;
		done = 1'b0;
		word = '0;
		bitClockIn = 1'b0;
		forever begin
			wait (go);
			#3;
			frame = 1'b0;
			word = '0;
			bitClockIn = inv; // Polarity change lands outside select
			#6;
			frame = 1'b1;
			for (int i = 0; i < nBits; i++) begin
				#6;
				bitClockIn = ~inv; // Update edge
				#6;
				bitClockIn = inv;
				word = {word[16:0], serialIn};
			end
			#6;
			frame = keep;
			done = 1'b1;
			wait (!go);
			done = 1'b0;
		end
	end
endmodule : acop_host_model

// [testbench/acop_port_chk.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module acop_port_chk
	import acop_pkg::*;
(
	input wire logic          clk,          // System clock
	input wire logic          arst_n,       // Async reset, active low
	input wire acop_pins_type pinsIn,       // Control pins
	input wire logic          csN,          // Chip select
	input wire logic          rdN,          // Read strobe
	input wire logic          busy,         // Conversion in progress
	input wire logic          holdSample,   // Hold state
	input wire logic          reducedPower, // Power-down in effect
	input wire acop_bus_type  dataBus       // Data pins
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic [CNT_W-1:0] busyCnt_q;
	logic [CNT_W-1:0] busyCnt_d;

	// Busy length; clears when idle so each conversion counts afresh
	always_comb begin
		busyCnt_d = busy ? busyCnt_q + CNT_ONE : '0;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busyCnt_q <= '0;
		end else begin
			busyCnt_q <= busyCnt_d;
		end
	end

	// Pin levels pass synchronisers, so mode checks wait 8 steady cycles
	hold_follow_a: assert property (holdSample == busy && ($rose(busy) -> !pinsIn.conversionStartN))
		else $error("hold differs from busy");
	busy_len_a: assert property ($fell(busy) && !pinsIn.resetIn |-> busyCnt_q == CNT_W'(CONV_CYC))
		else $error("busy length wrong");
	reset_abort_a: assert property (pinsIn.resetIn[*8] |-> !busy)
		else $error("busy under reset");
	pd_block_a: assert property (pinsIn.powerDownIn[*8] ##0 !busy |-> reducedPower ##1 !busy)
		else $error("power-down not kept");
	oe_gate_a: assert property ((csN || rdN) |-> dataBus.oe == 16'h0000)
		else $error("driver without select");
	par_drive_a: assert property ((!pinsIn.portFormatSelect)[*8] ##0 (!csN && !rdN) |-> dataBus.oe == 16'hffff)
		else $error("parallel bus not driven");
	hiz_top_a: assert property (pinsIn.portFormatSelect[*8] |-> dataBus.oe[15:12] == 4'h0)
		else $error("upper bits driven in serial");
	err_pulse_a: assert property ((pinsIn.portFormatSelect && pinsIn.clockSourceSelect)[*8] ##0
		(dataBus.oe[11] && dataBus.out[11]) |-> $fell(busy) ##1 !dataBus.out[11])
		else $error("error pulse misplaced");
	err_intl_a: assert property ((pinsIn.portFormatSelect && !pinsIn.clockSourceSelect)[*8] |-> !dataBus.oe[11])
		else $error("error pin driven in master mode");
	ext_clk_a: assert property ((pinsIn.portFormatSelect && pinsIn.clockSourceSelect)[*8] |-> dataBus.oe[10:9] == 2'h0)
		else $error("clock or sync driven in slave mode");
endmodule : acop_port_chk

bind acop_port acop_port_chk u_acop_port_chk (
	.clk(clk),
	.arst_n(arst_n),
	.pinsIn(pinsIn),
	.csN(csN),
	.rdN(rdN),
	.busy(busy),
	.holdSample(holdSample),
	.reducedPower(reducedPower),
	.dataBus(dataBus)
);

// [testbench/acop_port_test.sv]
`timescale 1ns/100ps
module acop_port_test
	import acop_pkg::*;
();
	logic          clk, arst_n, csN, rdN, bitClockIn, busy, holdSample, reducedPower;
	logic          go, inv, keep, selIn, done, sdWire, bcInv, fsInv, sclkQ, ch;
	acop_pins_type pins;
	acop_bus_type  dataBus;
	logic [15:0]   convResult, code, prev;
	logic [4:0]    nBits;
	logic [17:0]   word, capWord;
	integer        seed, err_count, compares, cycles, capN, errSeen;

	// Released wire shows a changing pattern, not a stale level
	assign sdWire = dataBus.oe[8] ? dataBus.out[8] : clk;

	acop_port u_acop_port (.clk(clk), .arst_n(arst_n), .pinsIn(pins), .csN(csN), .rdN(rdN),
		.bitClockIn(bitClockIn), .convResult(convResult), .busy(busy), .holdSample(holdSample),
		.reducedPower(reducedPower), .dataBus(dataBus));
	acop_host_model u_acop_host_model (.go(go), .nBits(nBits), .inv(inv), .keep(keep), .selIn(selIn),
		.serialIn(sdWire), .csN(csN), .rdN(rdN), .bitClockIn(bitClockIn), .word(word), .done(done));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Ceiling, error-flag count and master-mode capture on sclk edge
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			test_done();
		end
		sclkQ <= dataBus.out[9];
		if (pins.portFormatSelect && pins.clockSourceSelect && dataBus.oe[11] && dataBus.out[11] === 1'b1) errSeen <= errSeen + 1;
		if (dataBus.oe[10] && dataBus.out[10] === ~fsInv && sclkQ !== dataBus.out[9] && dataBus.out[9] === bcInv) begin
			capWord <= {capWord[16:0], dataBus.out[8]};
			capN <= capN + 1;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [17:0] expWord(input logic [15:0] c, input logic b);
		return {c, b, b};
	endfunction : expWord

	task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Sampled at the falling edge, where outputs have settled
	task automatic waitBusy(input logic lvl, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n = n + 1;
		end while (busy !== lvl && n < lim);
	endtask : waitBusy

	task automatic startLow();
		@(posedge clk);
		pins.conversionStartN <= 1'b0;
		waitBusy(1'b1, 20);
		chk("busy rise", busy, 1'b1);
	endtask : startLow

	task automatic convert(input logic [15:0] c);
		@(posedge clk);
		convResult <= c;
		startLow();
		@(posedge clk);
		pins.conversionStartN <= 1'b1;
		waitBusy(1'b0, 40);
		chk("busy fall", busy, 1'b0);
	endtask : convert

	task automatic hostRead(input logic [4:0] bits, input logic kp);
		int n;
		@(posedge clk);
		nBits <= bits;
		keep <= kp;
		go <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (done !== 1'b1 && n < 50);
		go <= 1'b0;
		chk("read done", done, 1'b1);
	endtask : hostRead

	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h0696;
		{err_count, compares, cycles, capN, errSeen} = '0;
		{arst_n, go, inv, keep, selIn, bcInv, fsInv, sclkQ, ch} = '0;
		pins = '0;
		pins.conversionStartN = 1'b1;
		{convResult, code, prev, capWord} = '0;
		nBits = 5'h10;
		tick(5);
		arst_n <= 1'b1;
		tick(8);
		for (int i = 0; i < 4; i++) begin
			code = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
			convert(code);
			@(posedge clk);
			selIn <= 1'b1;
			@(negedge clk);
			chk("parallel word", dataBus.out, code);
			chk("parallel enable", dataBus.oe, 16'hffff);
			@(posedge clk);
			selIn <= 1'b0;
			@(negedge clk);
			chk("released bus", dataBus.oe, 16'h0000);
		end
		$display("parallel test done");
		startLow();
		@(posedge clk);
		pins.conversionStartN <= 1'b1;
		tick(7);
		pins.conversionStartN <= 1'b0;
		tick(7);
		pins.conversionStartN <= 1'b1;
		waitBusy(1'b0, 40);
		waitBusy(1'b1, 12);
		chk("no restart", busy, 1'b0);
		startLow();
		@(posedge clk);
		pins.conversionStartN <= 1'b1;
		pins.powerDownIn <= 1'b1;
		waitBusy(1'b0, 40);
		chk("pd finishes", busy, 1'b0);
		tick(2);
		pins.conversionStartN <= 1'b0;
		tick(8);
		pins.conversionStartN <= 1'b1;
		waitBusy(1'b1, 20);
		chk("pd no start", busy, 1'b0);
		chk("reduced power", reducedPower, 1'b1);
		@(posedge clk);
		pins.powerDownIn <= 1'b0;
		startLow();
		@(posedge clk);
		pins.conversionStartN <= 1'b1;
		pins.resetIn <= 1'b1;
		waitBusy(1'b0, 10);
		chk("abort", busy, 1'b0);
		tick(9);
		pins.resetIn <= 1'b0;
		pins.lowPowerSelect <= 1'b1;
		tick(8);
		startLow();
		waitBusy(1'b0, 40);
		waitBusy(1'b1, 15);
		chk("auto restart", busy, 1'b1);
		@(posedge clk);
		pins.conversionStartN <= 1'b1;
		pins.lowPowerSelect <= 1'b0;
		waitBusy(1'b0, 40);
		$display("control test done");
		// Slave link, both clock polarities, chain bits after the word
		@(posedge clk);
		pins.portFormatSelect <= 1'b1;
		pins.clockSourceSelect <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			inv <= i[0];
			pins.bitClockInvert <= i[0];
			ch = 1'($random(seed));
			pins.readModeOrChainIn <= ch;
			tick(8);
			code = 16'($random(seed));
			convert(code);
			hostRead(5'h12, 1'b0);
			chk("link word", word, expWord(code, ch));
		end
		prev = code;
		hostRead(5'h08, 1'b0 + 1'b1);
		errSeen = 0;
		convert(~prev);
		tick(2);
		chk("overrun flag", 18'(errSeen), 18'h00001);
		hostRead(5'h12, 1'b0);
		chk("kept word", word[17:2], prev);
		$display("slave test done");
		// Master link, both read modes, random polarities
		@(posedge clk);
		pins.clockSourceSelect <= 1'b0;
		selIn <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			bcInv <= 1'($random(seed));
			fsInv <= 1'($random(seed));
			tick(1);
			pins.bitClockInvert <= bcInv;
			pins.frameSyncInvert <= fsInv;
			pins.readModeOrChainIn <= i[0];
			tick(8);
			prev = code;
			code = 16'($random(seed));
			capN <= 0;
			convert(code);
			for (int k = 0; k < 80 && capN < 16; k++) @(negedge clk);
			tick(4);
			@(negedge clk);
			chk("master word", capWord[15:0], i[0] ? prev : code);
			chk("bit count", 18'(capN), 18'h00010);
			chk("sync idle", dataBus.out[10], fsInv);
			chk("sclk driven", dataBus.oe[10:9], 2'h3);
		end
		$display("master test done");
		test_done();
	end
endmodule : acop_port_test
